//--- logic/rct_repeat_cycle_timer.v
// Repeat cycle timer with APB settings and status
`timescale 1ns/100ps
`include "rct_defines.vh"

// Functional notes
// - While start is powered the cycling output alternates ON and OFF periods without end.
// - ON and OFF periods have their own settings, each with its own one of four ranges.
// - A switch picks ON first or OFF first for each run, OFF first by default.
// - A switch picks restart or keep of elapsed state over a power interruption.
// - Ranges and options come from seven static switch inputs.
// - The display value has four and a half digits, at most 19999.
// - The annunciator blinks during the ON period and is steady during OFF.
// - The instantaneous output follows the start input regardless of phase.
// - Inhibit freezes timing without clearing elapsed time or phase.
// - Removing start resets the timer well within 30 ms.
// - After power returns the timer is operational within 300 ms.
// - Each period is timed from a freshly aligned timebase so repeats agree.
module rct_repeat_cycle_timer #(
    parameter integer TICK_CYC     = `RCT_CLK_HZ / 1000 * `RCT_TICK_MS,
    parameter integer POWER_ON_CYC = `RCT_CLK_HZ / 1000 * `RCT_POWER_ON_MS
) (
    input  wire        CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire        POWER_OK,
    input  wire        START,
    input  wire        INHIBIT,
    input  wire [6:0]  SWITCH,
    output reg         CYCLE_OUT,
    output reg         INST_OUT,
    output reg         ANN_OUT,
    output reg         PHASE_ON,
    output reg  [14:0] DISPLAY
);

    localparam integer TICK_LAST_I  = TICK_CYC - 1;
    localparam integer POWER_LAST_I = POWER_ON_CYC - 1;
    localparam [22:0]  TICK_LAST    = TICK_LAST_I[22:0];
    localparam [22:0]  POWER_LAST   = POWER_LAST_I[22:0];

    reg  [14:0] on_set_reg;
    reg  [14:0] off_set_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg         phase_reg;
    reg  [22:0] pre_reg;
    reg  [22:0] warm_reg;
    reg  [12:0] unit_reg;
    reg  [6:0]  lo_reg;
    reg  [7:0]  hi_reg;
    reg  [22:0] free_reg;
    reg  [12:0] blink_cnt_reg;
    reg         blink_reg;

    wire        acc     = PSEL & PENABLE;
    wire        wr      = acc & PWRITE;
    wire        hit_on  = (PADDR == `RCT_OFF_ON_SET);
    wire        hit_off = (PADDR == `RCT_OFF_OFF_SET);
    wire        hit_st  = (PADDR == `RCT_OFF_STATUS);
    wire        hit_el  = (PADDR == `RCT_OFF_ELAPSED);
    wire        mapped  = hit_on | hit_off | hit_st | hit_el;
    wire [14:0] wdata   = (PWDATA[14:0] > `RCT_DISP_MAX) ? `RCT_DISP_MAX
                                                           : PWDATA[14:0];

    assign PREADY  = 1'b1;
    assign PSLVERR = acc & ~mapped;

    // Settings registers
    wire wr_on  = wr & hit_on;
    wire wr_off = wr & hit_off;

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            on_set_reg <= `RCT_ON_SET_RST;
        end else if (wr_on) begin
            on_set_reg <= wdata;
        end
    end

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            off_set_reg <= `RCT_OFF_SET_RST;
        end else if (wr_off) begin
            off_set_reg <= wdata;
        end
    end

    // Current phase range and setting
    wire [1:0] rng_on  = SWITCH[`RCT_SW_ON_RNG_HI:`RCT_SW_ON_RNG_LO];
    wire [1:0] rng_off = SWITCH[`RCT_SW_OFF_RNG_HI:`RCT_SW_OFF_RNG_LO];
    wire [1:0] rng     = phase_reg ? rng_on : rng_off;
    wire [14:0] set_cur = phase_reg ? on_set_reg : off_set_reg;
    reg  [12:0] div;

    always @* begin
        case (rng)
            2'd0:    div = `RCT_DIV_R0;
            2'd1:    div = `RCT_DIV_R1;
            2'd2:    div = `RCT_DIV_R2;
            default: div = `RCT_DIV_R3;
        endcase
    end

    // Minute and hour ranges wrap the low pair at 59
    wire [6:0]  lo_wrap = rng[1] ? `RCT_LO_WRAP_SEX : `RCT_LO_WRAP_DEC;
    wire        lo_top  = (lo_reg == lo_wrap);
    wire [6:0]  lo_inc  = lo_top ? 7'h00 : lo_reg + 7'h01;
    wire [7:0]  hi_inc  = lo_top ? hi_reg + 8'h01 : hi_reg;
    wire [16:0] val_inc = hi_inc * `RCT_HUNDRED + {10'h000, lo_inc};
    wire [16:0] val_cur = hi_reg * `RCT_HUNDRED + {10'h000, lo_reg};

    // Timing advances only while running and not inhibited
    wire run       = (state_reg == `RCT_ST_RUN) & START & ~INHIBIT;
    wire tick10    = run & (pre_reg == TICK_LAST);
    wire unit_tick = tick10 & (unit_reg == div - 13'h0001);
    wire done      = unit_tick & (val_inc >= {2'b00, set_cur});
    wire begin_run = (state_reg == `RCT_ST_IDLE) & START & POWER_OK;
    wire retain    = SWITCH[`RCT_SW_RETAIN];

    // Run state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `RCT_ST_IDLE: begin
                if (!POWER_OK) begin
                    state_next = `RCT_ST_HOLD;
                end else if (START) begin
                    state_next = `RCT_ST_RUN;
                end
            end
            `RCT_ST_RUN: begin
                if (!POWER_OK) begin
                    state_next = `RCT_ST_HOLD;
                end else if (!START) begin
                    state_next = `RCT_ST_IDLE;
                end
            end
            `RCT_ST_HOLD: begin
                if (POWER_OK) begin
                    state_next = `RCT_ST_WARM;
                end
            end
            `RCT_ST_WARM: begin
                if (!POWER_OK) begin
                    state_next = `RCT_ST_HOLD;
                end else if (warm_reg == POWER_LAST) begin
                    state_next = START ? `RCT_ST_RUN : `RCT_ST_IDLE;
                end
            end
            default: state_next = `RCT_ST_IDLE;
        endcase
    end

    // Restart after power return unless retentive
    wire warm_done = (state_reg == `RCT_ST_WARM) &
                     (state_next == `RCT_ST_RUN);
    wire restart   = begin_run | (warm_done & ~retain);
    wire clear     = ((state_reg == `RCT_ST_RUN) & POWER_OK & ~START) |
                     ((state_reg == `RCT_ST_HOLD) & ~retain);

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_reg <= `RCT_ST_WARM;
        end else begin
            state_reg <= state_next;
        end
    end

    // Warm-up counter after power return
    wire warm_stay = (state_reg == `RCT_ST_WARM) &
                     (state_next == `RCT_ST_WARM);

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            warm_reg <= 23'h00_0000;
        end else if (warm_stay) begin
            warm_reg <= warm_reg + 23'h00_0001;
        end else begin
            warm_reg <= 23'h00_0000;
        end
    end

    // Current phase
    wire start_phase = restart | clear;

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            phase_reg <= 1'b0;
        end else if (start_phase) begin
            phase_reg <= SWITCH[`RCT_SW_ON_FIRST];
        end else if (done) begin
            phase_reg <= ~phase_reg;
        end
    end

    // Prescaler, aligned at each period start
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pre_reg <= 23'h00_0000;
        end else if (start_phase || done) begin
            pre_reg <= 23'h00_0000;
        end else if (run) begin
            pre_reg <= tick10 ? 23'h00_0000 : pre_reg + 23'h00_0001;
        end
    end

    // Resolution unit counter
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            unit_reg <= 13'h0000;
        end else if (start_phase || done || unit_tick) begin
            unit_reg <= 13'h0000;
        end else if (tick10) begin
            unit_reg <= unit_reg + 13'h0001;
        end
    end

    // Elapsed value pair
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            lo_reg <= 7'h00;
            hi_reg <= 8'h00;
        end else if (start_phase || done) begin
            lo_reg <= 7'h00;
            hi_reg <= 8'h00;
        end else if (unit_tick) begin
            lo_reg <= lo_inc;
            hi_reg <= hi_inc;
        end
    end

    // Free running blink timebase
    wire free_tick  = (free_reg == TICK_LAST);
    wire blink_wrap = (blink_cnt_reg == `RCT_BLINK_TICKS - 13'h0001);

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            free_reg <= 23'h00_0000;
        end else if (free_tick) begin
            free_reg <= 23'h00_0000;
        end else begin
            free_reg <= free_reg + 23'h00_0001;
        end
    end

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            blink_cnt_reg <= 13'h0000;
            blink_reg     <= 1'b0;
        end else if (free_tick) begin
            if (blink_wrap) begin
                blink_cnt_reg <= 13'h0000;
                blink_reg     <= ~blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 13'h0001;
            end
        end
    end

    // Display value, elapsed or remaining
    wire [16:0] remain = ({2'b00, set_cur} > val_cur) ?
                         {2'b00, set_cur} - val_cur : 17'h0_0000;
    wire [16:0] shown  = SWITCH[`RCT_SW_COUNT_DOWN] ? remain : val_cur;
    wire        active = (state_reg == `RCT_ST_RUN) & START;

    // Cycling relay drive
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            CYCLE_OUT <= 1'b0;
        end else begin
            CYCLE_OUT <= active & phase_reg;
        end
    end

    // Instantaneous relay drive
    wire inst_next = START & POWER_OK &
                     (state_reg != `RCT_ST_WARM) &
                     (state_reg != `RCT_ST_HOLD);

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            INST_OUT <= 1'b0;
        end else begin
            INST_OUT <= inst_next;
        end
    end

    // Annunciator
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ANN_OUT <= 1'b0;
        end else begin
            ANN_OUT <= active & (phase_reg ? blink_reg : 1'b1);
        end
    end

    // Phase indicator
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PHASE_ON <= 1'b0;
        end else begin
            PHASE_ON <= phase_reg;
        end
    end

    // Display clamp
    wire [14:0] disp_next = (shown > {2'b00, `RCT_DISP_MAX}) ?
                            `RCT_DISP_MAX : shown[14:0];

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            DISPLAY <= 15'h0000;
        end else begin
            DISPLAY <= disp_next;
        end
    end

    // Read word selected by address
    reg  [31:0] rd_word;

    always @* begin
        rd_word = 32'h0000_0000;
        case (PADDR)
            `RCT_OFF_ON_SET:  rd_word = {17'h0_0000, on_set_reg};
            `RCT_OFF_OFF_SET: rd_word = {17'h0_0000, off_set_reg};
            `RCT_OFF_STATUS:  rd_word = {21'h00_0000, SWITCH,
                                         state_reg, run, phase_reg};
            `RCT_OFF_ELAPSED: rd_word = {15'h0000, val_cur};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup cycle
    wire rd_setup = PSEL & ~PENABLE & ~PWRITE;

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA <= rd_word;
        end
    end

endmodule // rct_repeat_cycle_timer

//--- logic/rct_defines.vh
// Constants for the repeat cycle timer
`ifndef RCT_DEFINES_VH
`define RCT_DEFINES_VH

// Timebase
`define RCT_CLK_HZ          20000000
`define RCT_TICK_MS         10
`define RCT_POWER_ON_MS     300
`define RCT_RESET_MS        30
`define RCT_BLINK_TICKS     13'h0032

// Resolution units per range, in 10 ms ticks
`define RCT_DIV_R0          13'h0001
`define RCT_DIV_R1          13'h000A
`define RCT_DIV_R2          13'h0064
`define RCT_DIV_R3          13'h1770

// Low display pair wrap points
`define RCT_LO_WRAP_DEC     7'h63
`define RCT_LO_WRAP_SEX     7'h3B
`define RCT_HUNDRED         9'h064
`define RCT_DISP_MAX        15'h4E1F

// Switch field positions
`define RCT_SW_ON_RNG_LO    0
`define RCT_SW_ON_RNG_HI    1
`define RCT_SW_OFF_RNG_LO   2
`define RCT_SW_OFF_RNG_HI   3
`define RCT_SW_ON_FIRST     4
`define RCT_SW_RETAIN       5
`define RCT_SW_COUNT_DOWN   6

// Register offsets
`define RCT_OFF_ON_SET      8'h00
`define RCT_OFF_OFF_SET     8'h04
`define RCT_OFF_STATUS      8'h08
`define RCT_OFF_ELAPSED     8'h0C

// Reset values
`define RCT_ON_SET_RST      15'h03E8
`define RCT_OFF_SET_RST     15'h03E8

// Run states
`define RCT_ST_IDLE         2'h0
`define RCT_ST_RUN          2'h1
`define RCT_ST_HOLD         2'h2
`define RCT_ST_WARM         2'h3

`endif

//--- test/rct_timer_props.sv
// Port checker for the repeat cycle timer
`timescale 1ns/100ps
module rct_timer_props (
    input wire        CLK,
    input wire        RESET,
    input wire        PSEL,
    input wire        PENABLE,
    input wire [7:0]  PADDR,
    input wire        PSLVERR,
    input wire        POWER_OK,
    input wire        START,
    input wire        INHIBIT,
    input wire        CYCLE_OUT,
    input wire        INST_OUT,
    input wire        ANN_OUT,
    input wire        PHASE_ON,
    input wire [14:0] DISPLAY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    chk_err_map: assert property (PSEL && PENABLE |->
        PSLVERR == (PADDR > 8'h0C || PADDR[1:0] != 2'h0))
        else $error("slave error mismatch");
    chk_disp_max: assert property (DISPLAY <= 15'h4E1F)
        else $error("display above limit");
    chk_inst_cause: assert property ($rose(INST_OUT) |-> $past(START))
        else $error("instant output without start");
    chk_start_drop: assert property ($fell(START) |->
        ##[1:2] (!INST_OUT && !CYCLE_OUT && !ANN_OUT))
        else $error("slow reset on start removal");
    chk_power_drop: assert property (!POWER_OK [*3] |->
        !CYCLE_OUT && !INST_OUT)
        else $error("outputs on without power");
    chk_off_steady: assert property ((INST_OUT && !PHASE_ON) [*3]
        |-> ANN_OUT)
        else $error("annunciator not steady in off");
    chk_out_phase: assert property (INST_OUT && $past(INST_OUT)
        |-> CYCLE_OUT == PHASE_ON)
        else $error("cycle output off phase");
    chk_inhibit_freeze: assert property (INHIBIT && $past(INHIBIT)
        && $past(INHIBIT, 2) && INST_OUT && $past(INST_OUT)
        |-> $stable(PHASE_ON) && $stable(DISPLAY))
        else $error("timing moved under inhibit");
endmodule // rct_timer_props

bind rct_repeat_cycle_timer rct_timer_props u_rct_timer_props (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PSLVERR(PSLVERR), .POWER_OK(POWER_OK),
    .START(START), .INHIBIT(INHIBIT), .CYCLE_OUT(CYCLE_OUT),
    .INST_OUT(INST_OUT), .ANN_OUT(ANN_OUT), .PHASE_ON(PHASE_ON),
    .DISPLAY(DISPLAY));

//--- test/rct_wiring.sv
// Control wiring model: start, inhibit, power lines and relay load
`timescale 1ns/100ps
module rct_wiring (
    input  wire       clk,
    input  wire       start_req,
    input  wire       inh_req,
    input  wire       pwr_req,
    input  wire       relay,
    output reg        start_line = 1'b0,
    output reg        inh_line = 1'b0,
    output reg        pwr_line = 1'b1,
    output reg [15:0] n_switch = 16'h0000
);
    reg relay_q = 1'b0;
    always @(posedge clk) begin
        start_line <= start_req;
        inh_line <= inh_req;
        pwr_line <= pwr_req;
        relay_q <= relay;
        if (relay !== relay_q) n_switch <= n_switch + 16'h0001;
    end
endmodule // rct_wiring

//--- test/rct_repeat_cycle_timer_bench.sv
// Self-checking bench for the repeat cycle timer
`timescale 1ns/100ps
`include "rct_defines.vh"
module rct_repeat_cycle_timer_bench;
    localparam integer TICK = 2;
    localparam integer WARM = 20;
    reg         clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    reg         pwrite = 1'b0, start_req = 1'b0, inh_req = 1'b0;
    reg         pwr_req = 1'b1, er;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0000_0000, rd;
    reg  [6:0]  sw = 7'h00;
    wire [31:0] prdata;
    wire        pready, pslverr, cyc, inst, ann, ph, s_l, i_l, p_l;
    wire [14:0] disp;
    integer     n_errors = 0, n_compared = 0, r, a, b, c, on_s, off_s;
    rct_repeat_cycle_timer #(.TICK_CYC(TICK), .POWER_ON_CYC(WARM))
        u_rct_repeat_cycle_timer (.CLK(clk), .RESET(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .POWER_OK(p_l), .START(s_l), .INHIBIT(i_l),
        .SWITCH(sw), .CYCLE_OUT(cyc), .INST_OUT(inst), .ANN_OUT(ann),
        .PHASE_ON(ph), .DISPLAY(disp));
    rct_wiring u_rct_wiring (.clk(clk), .start_req(start_req),
        .inh_req(inh_req), .pwr_req(pwr_req), .relay(cyc),
        .start_line(s_l), .inh_line(i_l), .pwr_line(p_l), .n_switch());
    function integer plen(input integer s, input integer g);
        plen = (s == 0 ? 1 : s) * TICK *
               (g == 0 ? 1 : g == 1 ? 10 : g == 2 ? 100 : 6000);
    endfunction
    task report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk_len(input integer got, input integer exp);
        n_compared = n_compared + 1;
        if (got < exp - TICK || got > exp + TICK) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t length %0d not %0d", $time, got, exp);
        end
    endtask
    task chk_val(input [31:0] got, input [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t value %0h not %0h", $time, got, exp);
        end
    endtask
    task apb(input w, input [7:0] ad, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task edge_wait(output integer n, input integer inh_at);
        reg v;
        begin
            v = cyc;
            n = 0;
            while (cyc === v && n < 30000) begin
                @(posedge clk);
                n = n + 1;
                if (n == inh_at) inh_req <= 1'b1;
                if (n == inh_at + 30) inh_req <= 1'b0;
            end
        end
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        #(60000 * 50);
        n_errors = n_errors + 1;
        report_and_stop;
    end
    initial begin
        r = $urandom(32'h2483);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (WARM + 5) @(posedge clk);
        apb(1'b0, `RCT_OFF_ON_SET, 32'h0000_0000);
        chk_val(rd, 32'h0000_03E8);
        apb(1'b1, `RCT_OFF_ON_SET, 32'h0000_7530);
        apb(1'b0, `RCT_OFF_ON_SET, 32'h0000_0000);
        chk_val(rd, 32'h0000_4E1F);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk_val({rd[30:0], er}, 32'h0000_0001);
        for (r = 0; r < 4; r = r + 1) begin
            on_s = r == 0 ? 10 + $urandom % 10 :
                   r == 1 ? 1 + $urandom % 4 : r - 2;
            off_s = 1 + $urandom % 4;
            sw <= {2'b00, r[0], 2'((r + 1) % 3), 2'(r)};
            apb(1'b1, `RCT_OFF_ON_SET, on_s);
            apb(1'b1, `RCT_OFF_OFF_SET, off_s);
            apb(1'b0, `RCT_OFF_STATUS, 32'h0000_0000);
            chk_val({25'h000_0000, rd[10:4]}, {25'h000_0000, sw});
            start_req <= 1'b1;
            edge_wait(a, 0);
            chk_len(a, r[0] ? 3 : plen(off_s, (r + 1) % 3) + 3);
            chk_val({31'h0000_0000, cyc}, 32'h0000_0001);
            edge_wait(a, r == 0 ? 3 : 0);
            edge_wait(b, 0);
            edge_wait(c, 0);
            chk_len(a, plen(on_s, r) + (r == 0 ? 30 : 0));
            chk_len(b, plen(off_s, (r + 1) % 3));
            chk_len(c, plen(on_s, r));
            chk_val({31'h0000_0000, inst}, 32'h0000_0001);
            start_req <= 1'b0;
            repeat (8) @(posedge clk);
            chk_val({30'h0000_0000, inst, cyc}, 32'h0000_0000);
            chk_val({17'h0_0000, disp}, 32'h0000_0000);
        end
        sw <= 7'h50;
        apb(1'b1, `RCT_OFF_ON_SET, 32'h0000_000F);
        start_req <= 1'b1;
        repeat (12) @(posedge clk);
        pwr_req <= 1'b0;
        repeat (4) @(posedge clk);
        pwr_req <= 1'b1;
        edge_wait(a, 0);
        chk_val({31'h0000_0000, a <= WARM + 8}, 32'h0000_0001);
        chk_val({17'h0_0000, disp}, 32'h0000_000F);
        edge_wait(b, 0);
        chk_len(b, plen(15, 0));
        report_and_stop;
    end
endmodule // rct_repeat_cycle_timer_bench
